//--- core/aux_cal_register_bank.sv
// Auxiliary monitor, event flag and calibration register bank
// Notes on behaviour
// - Auxiliary power bit 1 switches the temperature monitor on or off.
// - Auxiliary power bit 0 switches the battery monitor on or off.
// - Converter result bits 7:2 read in high [5:0], bits 1:0 in low [7:6].
// - Five-bit field sets battery trip level, 1.7 V plus 62 mV per count.
// - Supply below battery threshold sets secondary flag bit 7 and raises alarm, only while aux power bit 0 is set.
// - Four-bit divider, reset 4, divides crystal for external clock; zero disables.
// - Gain loop updates at 26 MHz over 16 times eight-bit divider, reset 40.
// - Primary flag bit 7 sets when wake-up count reaches its limit.
// - Primary flag bit 6 sets when smart wake strength exceeds its limit.
// - Primary flag bit 5 sets on cipher done, only with cipher firmware loaded.
// - Primary flag bit 4 sets on transmit end, packet mode only.
// - Primary flag bit 3 sets on received address match, packet mode only.
// - Primary flag bit 2 sets on correct received checksum, packet mode only.
// - Primary flag bit 1 sets on qualified sync word detection.
// - Primary flag bit 0 sets on qualified preamble detection.
// - Secondary bit 6 sets on command ready, bit 0 on command finished.
// - Secondary bit 4 on wake timer expiry, bit 1 on port ready; 5,3,2 unused.
// - Calibration control bit 1 enables the synthesizer calibration machine.
// - Calibration control bit 0 enables receive filter calibration.
// - Status bit 1 reads 1 when synthesizer calibration finished and enabled, else 0.
// - Status bit 0 reads 1 when filter calibration finished and enabled, else 0.
// - Six-bit filter calibration word readable after a calibration cycle.
`timescale 1ns/1ps
`include "aux_cal_regs_defs.svh"

module aux_cal_register_bank #(
  parameter int unsigned GAIN_PRESCALE = `GAIN_LOOP_PRESCALE
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic [`ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]          regWrData,
  input  wire logic                regWrStb,
  input  wire logic                regRdStb,
  output logic      [7:0]          regRdData,
  input  wire logic [7:0]          convResult,
  input  wire logic                supplyBelowTrip,
  input  wire logic                wakeupCountReached,
  input  wire logic                smartWakeStrength,
  input  wire logic                cipherDone,
  input  wire logic                cipherLoaded,
  input  wire logic                packetMode,
  input  wire logic                txDone,
  input  wire logic                addrMatch,
  input  wire logic                crcCorrect,
  input  wire logic                syncDetect,
  input  wire logic                preambleDetect,
  input  wire logic                cmdReady,
  input  wire logic                cmdFinished,
  input  wire logic                wakeTimerExpired,
  input  wire logic                portReady,
  input  wire logic                synthCalDone,
  input  wire logic                rxFilterCalDone,
  input  wire logic                ampRampDone,
  input  wire logic [5:0]          rxFilterCalWord,
  input  wire logic                xtalTick,
  output logic                     tempMonitorEnable,
  output logic                     batteryMonitorEnable,
  output logic      [4:0]          batteryTripLevel,
  output logic                     batteryAlarm,
  output logic                     extClockOut,
  output logic                     gainLoopTick,
  output logic                     synthCalEnable,
  output logic                     rxFilterCalEnable
);

  aux_cal_regs_pkg::bank_state_s state_r;
  aux_cal_regs_pkg::bank_state_s state_nxt;

  logic [7:0] priEvents;
  logic [7:0] secEvents;
  logic       wrHit;

  always_comb
  begin
    priEvents = {wakeupCountReached,
                 smartWakeStrength,
                 cipherDone & cipherLoaded,
                 txDone & packetMode,
                 addrMatch & packetMode,
                 crcCorrect & packetMode,
                 syncDetect,
                 preambleDetect};
    secEvents = {supplyBelowTrip & state_r.auxPower[`BIT_BATT_MON],
                 cmdReady,
                 1'b0,
                 wakeTimerExpired,
                 2'b00,
                 portReady,
                 cmdFinished};
    wrHit = regWrStb;
  end

  always_comb
  begin
    state_nxt = state_r;
    state_nxt.rdData = 8'h00;
    if (wrHit)
    begin
      case (regAddr)
        `OFS_AUX_MON_POWER: state_nxt.auxPower = regWrData[1:0];
        `OFS_BATT_THRESH:   state_nxt.battTrip = regWrData[4:0];
        `OFS_EXT_CLK_DIV:   state_nxt.extDiv   = regWrData[3:0];
        `OFS_GAIN_CLK_DIV:  state_nxt.gainDiv  = regWrData;
        `OFS_FLAGS_PRI:     state_nxt.flagsPri = regWrData;
        `OFS_FLAGS_SEC:     state_nxt.flagsSec = regWrData & `SEC_USED_MASK;
        `OFS_CAL_ENABLES:   state_nxt.calEn    = regWrData[1:0];
        default:            state_nxt.calEn    = state_nxt.calEn;
      endcase
    end
    // Events are ORed after the write so a set in the clearing cycle survives
    state_nxt.flagsPri = state_nxt.flagsPri | priEvents;
    state_nxt.flagsSec = state_nxt.flagsSec | secEvents;

    if (regRdStb)
    begin
      case (regAddr)
        `OFS_AUX_MON_POWER: state_nxt.rdData = {6'h00, state_r.auxPower};
        `OFS_CONV_RES_HIGH: state_nxt.rdData = {2'b00, convResult[7:2]};
        `OFS_CONV_RES_LOW:  state_nxt.rdData = {convResult[1:0], 6'h00};
        `OFS_BATT_THRESH:   state_nxt.rdData = {3'b000, state_r.battTrip};
        `OFS_EXT_CLK_DIV:   state_nxt.rdData = {4'h0, state_r.extDiv};
        `OFS_GAIN_CLK_DIV:  state_nxt.rdData = state_r.gainDiv;
        `OFS_FLAGS_PRI:     state_nxt.rdData = state_r.flagsPri;
        `OFS_FLAGS_SEC:     state_nxt.rdData = state_r.flagsSec;
        `OFS_CAL_ENABLES:   state_nxt.rdData = {6'h00, state_r.calEn};
        `OFS_CAL_PROGRESS:
          state_nxt.rdData = {5'h00, ampRampDone,
                              synthCalDone & state_r.calEn[`BIT_SYNTH_CAL],
                              rxFilterCalDone & state_r.calEn[`BIT_RXF_CAL]};
        `OFS_FCAL_WORD:     state_nxt.rdData = {2'b00, rxFilterCalWord};
        default:            state_nxt.rdData = 8'h00;
      endcase
    end

    // External clock: toggles every extDiv/2 crystal ticks; odd divide rounds duty
    if (state_r.extDiv == 4'h0)
    begin
      state_nxt.extCnt = 4'h0;
      state_nxt.extClk = 1'b0;
    end
    else if (xtalTick)
    begin
      if (state_r.extCnt >= state_r.extDiv - 4'h1)
      begin
        state_nxt.extCnt = 4'h0;
        state_nxt.extClk = 1'b1;
      end
      else
      begin
        state_nxt.extCnt = state_r.extCnt + 4'h1;
        if (state_r.extCnt + 4'h1 >= {1'b0, state_r.extDiv[3:1]})
          state_nxt.extClk = 1'b0;
      end
    end

    // Gain loop tick: prescale by 16 then by gainDiv; zero divider holds it off
    state_nxt.gainTick = 1'b0;
    if (xtalTick && state_r.gainDiv != 8'h00)
    begin
      if (state_r.gainPre == 4'(GAIN_PRESCALE - 1))
      begin
        state_nxt.gainPre = 4'h0;
        if (state_r.gainCnt >= state_r.gainDiv - 8'h01)
        begin
          state_nxt.gainCnt  = 8'h00;
          state_nxt.gainTick = 1'b1;
        end
        else
          state_nxt.gainCnt = state_r.gainCnt + 8'h01;
      end
      else
        state_nxt.gainPre = state_r.gainPre + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r          <= '0;
      state_r.extDiv   <= `RST_EXT_CLK_DIV;
      state_r.gainDiv  <= `RST_GAIN_CLK_DIV;
    end
    else
      state_r <= state_nxt;
  end

  assign regRdData            = state_r.rdData;
  assign tempMonitorEnable    = state_r.auxPower[`BIT_TEMP_MON];
  assign batteryMonitorEnable = state_r.auxPower[`BIT_BATT_MON];
  assign batteryTripLevel     = state_r.battTrip;
  assign batteryAlarm         = state_r.flagsSec[7];
  assign extClockOut          = state_r.extClk;
  assign gainLoopTick         = state_r.gainTick;
  assign synthCalEnable       = state_r.calEn[`BIT_SYNTH_CAL];
  assign rxFilterCalEnable    = state_r.calEn[`BIT_RXF_CAL];

endmodule // aux_cal_register_bank

//--- core/aux_cal_regs_defs.svh
// Register offsets, field positions, reset values and timing counts of the auxiliary bank
`ifndef AUX_CAL_REGS_DEFS_SVH
`define AUX_CAL_REGS_DEFS_SVH

`define ADDR_W               10
`define OFS_AUX_MON_POWER    10'h325
`define OFS_CONV_RES_HIGH    10'h327
`define OFS_CONV_RES_LOW     10'h328
`define OFS_BATT_THRESH      10'h32D
`define OFS_EXT_CLK_DIV      10'h32E
`define OFS_GAIN_CLK_DIV     10'h32F
`define OFS_FLAGS_PRI        10'h336
`define OFS_FLAGS_SEC        10'h337
`define OFS_CAL_ENABLES      10'h338
`define OFS_CAL_PROGRESS     10'h339
`define OFS_FCAL_WORD        10'h345

`define RST_EXT_CLK_DIV      4'h4
`define RST_GAIN_CLK_DIV     8'h28

`define BIT_TEMP_MON         1
`define BIT_BATT_MON         0
`define BIT_SYNTH_CAL        1
`define BIT_RXF_CAL          0
`define BIT_AMP_RAMP         2
`define SEC_USED_MASK        8'hD3

`define GAIN_LOOP_PRESCALE   16

`endif

//--- core/aux_cal_regs_pkg.sv
// Types of the auxiliary and calibration register bank
package aux_cal_regs_pkg;

  typedef struct packed {
    logic [1:0] auxPower;
    logic [4:0] battTrip;
    logic [3:0] extDiv;
    logic [7:0] gainDiv;
    logic [7:0] flagsPri;
    logic [7:0] flagsSec;
    logic [1:0] calEn;
    logic [7:0] rdData;
    logic [3:0] extCnt;
    logic       extClk;
    logic [7:0] gainCnt;
    logic [3:0] gainPre;
    logic       gainTick;
  } bank_state_s;

endpackage

//--- tb/aux_cal_props.sv
// Assertions on the ports of the auxiliary register bank
`timescale 1ns/1ps
`include "aux_cal_regs_defs.svh"
module aux_cal_props (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic [`ADDR_W-1:0] regAddr,
  input wire logic [7:0]         regWrData,
  input wire logic               regWrStb,
  input wire logic               regRdStb,
  input wire logic [7:0]         regRdData,
  input wire logic [7:0]         convResult,
  input wire logic               supplyBelowTrip,
  input wire logic               tempMonitorEnable,
  input wire logic               batteryMonitorEnable,
  input wire logic [4:0]         batteryTripLevel,
  input wire logic               batteryAlarm,
  input wire logic               synthCalEnable,
  input wire logic               rxFilterCalEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire wAux = regWrStb && regAddr == `OFS_AUX_MON_POWER;
  wire wCal = regWrStb && regAddr == `OFS_CAL_ENABLES;
  a_temp_follows: assert property (wAux |=> tempMonitorEnable == $past(regWrData[1]))
    else $error("temp monitor enable wrong");
  a_batt_follows: assert property (wAux |=> batteryMonitorEnable == $past(regWrData[0]))
    else $error("battery monitor enable wrong");
  a_synth_follows: assert property (wCal |=> synthCalEnable == $past(regWrData[1]))
    else $error("synth cal enable wrong");
  a_filter_follows: assert property (wCal |=> rxFilterCalEnable == $past(regWrData[0]))
    else $error("filter cal enable wrong");
  a_trip_level: assert property (regWrStb && regAddr == `OFS_BATT_THRESH
    |=> batteryTripLevel == $past(regWrData[4:0])) else $error("trip level wrong");
  a_conv_high: assert property (regRdStb && regAddr == `OFS_CONV_RES_HIGH
    |=> regRdData == {2'b00, $past(convResult[7:2])}) else $error("result high wrong");
  a_alarm_raise: assert property (supplyBelowTrip && batteryMonitorEnable
    |-> ##[1:2] batteryAlarm) else $error("alarm not raised");
  a_rd_idle: assert property (!regRdStb |=> regRdData == 8'h00)
    else $error("read data not idle");
  c_aux_write: cover property (wAux && regWrData[1:0] == 2'b11);
  c_conv_read: cover property (regRdStb && regAddr == `OFS_CONV_RES_HIGH);
  c_alarm: cover property ($rose(batteryAlarm));
endmodule // aux_cal_props

bind aux_cal_register_bank aux_cal_props props_u (.clk(clk), .rstn(rstn), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .convResult(convResult), .supplyBelowTrip(supplyBelowTrip),
  .tempMonitorEnable(tempMonitorEnable), .batteryMonitorEnable(batteryMonitorEnable),
  .batteryTripLevel(batteryTripLevel), .batteryAlarm(batteryAlarm),
  .synthCalEnable(synthCalEnable), .rxFilterCalEnable(rxFilterCalEnable));

//--- tb/aux_cal_register_bank_bench.sv
// Self-checking bench for the auxiliary register bank
`timescale 1ns/1ps
`include "aux_cal_regs_defs.svh"
module aux_cal_register_bank_bench;
  logic clk = 0, rstn = 0, wrStb = 0, rdStb = 0, xt = 0, pm = 1, cl = 1;
  logic [9:0] addr = '0;
  logic [7:0] wd = '0, rdd, ev = '0, sev = '0, conv = '0;
  logic [5:0] cw = '0;
  logic [2:0] cal = '0;
  logic te, be, ba, eo, gt, se, re;
  logic [4:0] tl;
  int fail_count = 0, num_checks = 0, cyc = 0;
  logic [9:0] ofs[11] = '{`OFS_AUX_MON_POWER, `OFS_CONV_RES_HIGH, `OFS_CONV_RES_LOW,
    `OFS_BATT_THRESH, `OFS_EXT_CLK_DIV, `OFS_GAIN_CLK_DIV, `OFS_FLAGS_PRI, `OFS_FLAGS_SEC,
    `OFS_CAL_ENABLES, `OFS_CAL_PROGRESS, `OFS_FCAL_WORD};
  logic [7:0] rv[11] = '{0, 0, 0, 0, 8'h04, 8'h28, 0, 0, 0, 0, 0};
  logic [7:0] wv[11] = '{8'h03, 0, 0, 8'h1F, 8'h0F, 8'hFF, 8'hFF, 8'hD3, 8'h03, 0, 0};
  logic [7:0] sv[5] = '{8'h80, 8'h40, 8'h10, 8'h02, 8'h01};
  always #5 clk = ~clk;
  always @(posedge clk) xt <= ~xt;
  aux_cal_register_bank #(.GAIN_PRESCALE(2)) dut_u (.clk(clk), .rstn(rstn), .regAddr(addr),
    .regWrData(wd), .regWrStb(wrStb), .regRdStb(rdStb), .regRdData(rdd), .convResult(conv),
    .supplyBelowTrip(sev[7]), .wakeupCountReached(ev[7]), .smartWakeStrength(ev[6]),
    .cipherDone(ev[5]), .cipherLoaded(cl), .packetMode(pm), .txDone(ev[4]),
    .addrMatch(ev[3]), .crcCorrect(ev[2]), .syncDetect(ev[1]), .preambleDetect(ev[0]),
    .cmdReady(sev[6]), .cmdFinished(sev[0]), .wakeTimerExpired(sev[4]), .portReady(sev[1]),
    .synthCalDone(cal[1]), .rxFilterCalDone(cal[0]), .ampRampDone(cal[2]),
    .rxFilterCalWord(cw), .xtalTick(xt), .tempMonitorEnable(te), .batteryMonitorEnable(be),
    .batteryTripLevel(tl), .batteryAlarm(ba), .extClockOut(eo), .gainLoopTick(gt),
    .synthCalEnable(se), .rxFilterCalEnable(re));
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wrStb <= 1;
    @(posedge clk);
    wrStb <= 0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(logic [9:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rdStb <= 1;
    @(posedge clk);
    rdStb <= 0;
    #1 chk($sformatf("reg %h", a), e, rdd);
  endtask
  task automatic pulse(logic [7:0] p, logic [7:0] s);
    @(posedge clk);
    ev <= p;
    sev <= s;
    @(posedge clk);
    ev <= 0;
    sev <= 0;
  endtask
  // Cycles between two rising edges of extClockOut (sel 0) or gainLoopTick (sel 1)
  task automatic gap(string n, bit sel, int e);
    int k;
    k = 0;
    @(posedge clk iff (sel ? gt : eo) === 1'b0);
    @(posedge clk iff (sel ? gt : eo) === 1'b1);
    do
    begin
      @(posedge clk);
      k++;
    end while ((sel ? gt : eo) !== 1'b0);
    do
    begin
      @(posedge clk);
      k++;
    end while ((sel ? gt : eo) !== 1'b1);
    chk(n, 8'(e), 8'(k));
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      finish_test;
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    foreach (ofs[i]) rd(ofs[i], rv[i]);
    foreach (ofs[i]) wr(ofs[i], 8'hFF);
    foreach (ofs[i]) rd(ofs[i], wv[i]);
    chk("enables", 8'h0F, {4'h0, te, be, se, re});
    chk("trip", 8'h1F, {3'h0, tl});
    wr(`OFS_FLAGS_PRI, 8'h00);
    wr(`OFS_FLAGS_SEC, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i, 8'h00);
      rd(`OFS_FLAGS_PRI, 8'h01 << i);
      wr(`OFS_FLAGS_PRI, 8'h00);
    end
    foreach (sv[i])
    begin
      pulse(8'h00, sv[i]);
      rd(`OFS_FLAGS_SEC, sv[i]);
      wr(`OFS_FLAGS_SEC, 8'h00);
    end
    pm <= 0;
    cl <= 0;
    pulse(8'h3C, 8'h00);
    rd(`OFS_FLAGS_PRI, 8'h00);
    wr(`OFS_AUX_MON_POWER, 8'h00);
    pulse(8'h00, 8'h80);
    rd(`OFS_FLAGS_SEC, 8'h00);
    conv <= 8'hB6;
    cw <= 6'h2A;
    cal <= 3'h7;
    rd(`OFS_CONV_RES_HIGH, 8'h2D);
    rd(`OFS_CONV_RES_LOW, 8'h80);
    rd(`OFS_CAL_PROGRESS, 8'h07);
    rd(`OFS_FCAL_WORD, 8'h2A);
    wr(`OFS_CAL_ENABLES, 8'h00);
    rd(`OFS_CAL_PROGRESS, 8'h04);
    rd(10'h300, 8'h00);
    // xtalTick every 2 clocks, prescale 2, divider 3: one tick per 12 clocks
    wr(`OFS_GAIN_CLK_DIV, 8'h03);
    gap("gainTick period", 1'b1, 12);
    // Divider 4 of a tick every 2 clocks gives an 8-clock period
    wr(`OFS_EXT_CLK_DIV, 8'h04);
    gap("extClk period", 1'b0, 8);
    wr(`OFS_EXT_CLK_DIV, 8'h00);
    repeat (40)
    begin
      @(posedge clk);
      #1 chk("extClk", 8'h00, {7'h0, eo});
    end
    finish_test;
  end
endmodule // aux_cal_register_bank_bench
